// ### supply_adc_cfg.svh
// register offsets, field positions and reset values for the supply and converter control block
`ifndef SUPPLY_ADC_CFG_SVH
`define SUPPLY_ADC_CFG_SVH

`define SUPPLY_PUMP_CONTROL_ADDR        8'h1F
`define CONVERTER_CONTROL_ADDR          8'h18
`define CHOPPER_DIVIDER_ADDR            8'h1A
`define EVENT_STATUS_ADDR               8'h1B

`define SPC_MODULE_EN_BIT               0
`define SPC_DOUBLER_EN_BIT              1
`define SPC_FAST_START_BIT              2
`define SPC_DIV_LSB                     3
`define SPC_DIV_MSB                     7
`define SPC_RESET                       8'h00

`define CCR_POWER_EN_BIT                0
`define CCR_PHASE_LSB                   1
`define CCR_PHASE_MSB                   2
`define CCR_CMP_BIT                     3
`define CCR_MODE_LSB                    4
`define CCR_MODE_MSB                    5
`define CCR_CHOP_EN_BIT                 6
`define CCR_RESET                       8'h00
`define CCR_WRITE_MASK                  8'h77

`define CDR_DIV_LSB                     0
`define CDR_DIV_MSB                     2
`define CDR_INPUT_SEL_BIT               3
`define CDR_REF_RATIO_BIT               4
`define CDR_GAIN_SEL_BIT                7
`define CDR_RESET                       8'h00
`define CDR_WRITE_MASK                  8'h9F

`define PUMP_PRESCALE                   16
`define CHOP_PRESCALE                   32

`endif

// ### supply_adc_pkg.sv
// types shared by the supply and converter control block
package supply_adc_pkg;
  typedef enum logic [1:0] {
    PHASE_RSVD0    = 2'b00,
    PHASE_CHARGE   = 2'b01,
    PHASE_DISCHARGE = 2'b10,
    PHASE_RSVD3    = 2'b11
  } slope_phase_t;

  typedef enum logic [1:0] {
    EVT_NONE    = 2'b00,
    EVT_RISING  = 2'b01,
    EVT_FALLING = 2'b10,
    EVT_BOTH    = 2'b11
  } event_mode_t;
endpackage

// ### clock_divider.sv
// fixed prescaler followed by a programmable divider, square-ish output
`include "supply_adc_cfg.svh"
module clock_divider #(
  parameter int PRESCALE = 16
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic [7:0] ratio,    // divide by ratio+1 after prescale
  output logic            clk_out
);
  logic [4:0] pre_reg;
  logic [4:0] pre_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       out_reg;
  logic       out_next;

  // prescaler ticks, then ratio counter toggles the output each full period half
  always_comb begin
    pre_next = pre_reg;
    cnt_next = cnt_reg;
    out_next = out_reg;
    if (!enable) begin
      pre_next = 5'h00;
      cnt_next = 8'h00;
      out_next = 1'b0;
    end else if (pre_reg == 5'(PRESCALE / 2 - 1)) begin
      pre_next = 5'h00;
      if (cnt_reg >= ratio) begin
        cnt_next = 8'h00;
        out_next = !out_reg;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end else begin
      pre_next = pre_reg + 5'h01;
    end
  end

  // register the divider state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_reg <= 5'h00;
      cnt_reg <= 8'h00;
      out_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign clk_out = out_reg;
endmodule

// ### edge_event.sv
// two-stage synchroniser and edge detector for the comparator output
module edge_event (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      async_in,
  input  wire supply_adc_pkg::event_mode_t mode,
  output logic                           level,
  output logic                           event_pulse
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  logic rise;
  logic fall;

  // synchroniser and previous value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // edge qualification by mode, one pulse per edge
  always_comb begin
    rise = sync_reg & !last_reg;
    fall = !sync_reg & last_reg;
    unique case (mode)
      supply_adc_pkg::EVT_NONE:    event_pulse = 1'b0;
      supply_adc_pkg::EVT_RISING:  event_pulse = rise;
      supply_adc_pkg::EVT_FALLING: event_pulse = fall;
      supply_adc_pkg::EVT_BOTH:    event_pulse = rise | fall;
    endcase
  end

  assign level = sync_reg;
endmodule

// ### supply_adc_ctrl.sv
// register file and control outputs for the supply module and dual-slope converter front end
`include "supply_adc_cfg.svh"

// Overview of operation
// - bit 0 enables supply module
// - bit 1 enables doubler, only if module on
// - bit 2 low shorts filter resistor
// - bits 3-7 divide pump clock by N+1 after 16
// - module off: regulator, reference, doubler and converter power off, doubler bypass, output floats
// - module on, doubler off: regulator only
// - both on: doubler feeds regulator
// - reference follows regulator enable
// - power bit switches converter analog blocks
// - chopper clock runs only when enabled
// - phase field picks charge or discharge
// - comparator bit read-only, live state
// - mode field picks interrupting comparator edges
// - input select picks chopped or bridge pin
// - gain select gives gain 2 or 4
// - ratio bit picks reference resistor tap
// - phase 01 charge, 10 discharge, others reserved
// - mode 00 none,01 rise,10 fall,11 both
// - chopper clock is fsys/32 over 2^n
module supply_adc_ctrl (
  input  wire logic       MCLK,
  input  wire logic       RST_N,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       COMPARATOR_IN,
  output logic            COMPARATOR_IRQ,
  output logic            REGULATOR_ON,
  output logic            REFERENCE_ON,
  output logic            FILTER_SHORT,
  output logic            DOUBLER_ON,
  output logic            DOUBLER_BYPASS,
  output logic            DOUBLER_CLK,
  output logic            REGULATED_OUTPUT_FLOAT,
  output logic            CONVERTER_POWER,
  output logic            CHOPPER_CLK,
  output logic            CHARGE_PHASE,
  output logic            DISCHARGE_PHASE,
  output logic            INPUT_BRIDGE_SEL,
  output logic            GAIN_FOUR,
  output logic            REF_RATIO_HIGH
);
  logic [7:0] spc_reg;
  logic [7:0] spc_next;
  logic [7:0] ccr_reg;
  logic [7:0] ccr_next;
  logic [7:0] cdr_reg;
  logic [7:0] cdr_next;
  logic       flag_reg;
  logic       flag_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] outs_reg;
  logic [7:0] outs_next;

  logic       module_en;
  logic       doubler_en;
  logic       cmp_level;
  logic       cmp_event;
  logic [7:0] pump_ratio;
  logic [7:0] chop_ratio;
  logic       doubler_clk_raw;
  logic       chopper_clk_raw;
  supply_adc_pkg::slope_phase_t phase;
  supply_adc_pkg::event_mode_t  mode;

  // field extraction
  assign module_en  = spc_reg[`SPC_MODULE_EN_BIT];
  assign doubler_en = module_en & spc_reg[`SPC_DOUBLER_EN_BIT];
  assign phase      = supply_adc_pkg::slope_phase_t'(ccr_reg[`CCR_PHASE_MSB:`CCR_PHASE_LSB]);
  assign mode       = supply_adc_pkg::event_mode_t'(ccr_reg[`CCR_MODE_MSB:`CCR_MODE_LSB]);

  // chopper ratio as 2^n - 1 counts of the prescaled tick
  function automatic logic [7:0] pow2_ratio(input logic [2:0] n);
    pow2_ratio = 8'((9'h001 << n) - 9'h001);
  endfunction

  assign pump_ratio = {3'h0, spc_reg[`SPC_DIV_MSB:`SPC_DIV_LSB]};
  assign chop_ratio = pow2_ratio(cdr_reg[`CDR_DIV_MSB:`CDR_DIV_LSB]);

  // doubler clock: fsys/16/(N+1), runs only while doubler active
  clock_divider #(
    .PRESCALE (`PUMP_PRESCALE)
  ) pump_div (
    .clk     (MCLK),
    .rst_n   (RST_N),
    .enable  (doubler_en),
    .ratio   (pump_ratio),
    .clk_out (doubler_clk_raw)
  );

  // chopper clock: fsys/32/2^n, stopped when the enable is low
  clock_divider #(
    .PRESCALE (`CHOP_PRESCALE)
  ) chop_div (
    .clk     (MCLK),
    .rst_n   (RST_N),
    .enable  (ccr_reg[`CCR_CHOP_EN_BIT]),
    .ratio   (chop_ratio),
    .clk_out (chopper_clk_raw)
  );

  // comparator synchroniser and edge qualification
  edge_event cmp_edge (
    .clk         (MCLK),
    .rst_n       (RST_N),
    .async_in    (COMPARATOR_IN),
    .mode        (mode),
    .level       (cmp_level),
    .event_pulse (cmp_event)
  );

  // register writes, sticky flag with set winning over clear, read mux
  always_comb begin
    spc_next   = spc_reg;
    ccr_next   = ccr_reg;
    cdr_next   = cdr_reg;
    flag_next  = flag_reg;
    rdata_next = 8'h00;
    if (WR) begin
      unique case (ADDR)
        `SUPPLY_PUMP_CONTROL_ADDR: spc_next = WDATA;
        `CONVERTER_CONTROL_ADDR:   ccr_next = WDATA & `CCR_WRITE_MASK;
        `CHOPPER_DIVIDER_ADDR:     cdr_next = WDATA & `CDR_WRITE_MASK;
        `EVENT_STATUS_ADDR:        if (WDATA[0]) flag_next = 1'b0;
        default: ;
      endcase
    end
    if (cmp_event) begin
      flag_next = 1'b1;
    end
    if (RD) begin
      unique case (ADDR)
        `SUPPLY_PUMP_CONTROL_ADDR: rdata_next = spc_reg;
        `CONVERTER_CONTROL_ADDR:   rdata_next = ccr_reg | {4'h0, cmp_level, 3'h0};
        `CHOPPER_DIVIDER_ADDR:     rdata_next = cdr_reg;
        `EVENT_STATUS_ADDR:        rdata_next = {7'h00, flag_reg};
        default:                   rdata_next = 8'h00;
      endcase
    end
  end

  // analog control levels from the registers
  always_comb begin
    outs_next[0] = module_en;
    outs_next[1] = module_en;
    outs_next[2] = !spc_reg[`SPC_FAST_START_BIT];
    outs_next[3] = doubler_en;
    outs_next[4] = !doubler_en;
    outs_next[5] = !module_en;
    outs_next[6] = module_en & ccr_reg[`CCR_POWER_EN_BIT];
    outs_next[7] = 1'b0;
  end

  // register state
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      spc_reg   <= `SPC_RESET;
      ccr_reg   <= `CCR_RESET;
      cdr_reg   <= `CDR_RESET;
      flag_reg  <= 1'b0;
      rdata_reg <= 8'h00;
      outs_reg  <= 8'h34;                                          // module off: short, bypass, float
    end else begin
      spc_reg   <= spc_next;
      ccr_reg   <= ccr_next;
      cdr_reg   <= cdr_next;
      flag_reg  <= flag_next;
      rdata_reg <= rdata_next;
      outs_reg  <= outs_next;
    end
  end

  assign RDATA                  = rdata_reg;
  assign COMPARATOR_IRQ         = flag_reg;
  assign REGULATOR_ON           = outs_reg[0];
  assign REFERENCE_ON           = outs_reg[1];
  assign FILTER_SHORT           = outs_reg[2];
  assign DOUBLER_ON             = outs_reg[3];
  assign DOUBLER_BYPASS         = outs_reg[4];
  assign REGULATED_OUTPUT_FLOAT = outs_reg[5];
  assign CONVERTER_POWER        = outs_reg[6];
  assign DOUBLER_CLK            = doubler_clk_raw;
  assign CHOPPER_CLK            = chopper_clk_raw;
  assign CHARGE_PHASE           = (phase == supply_adc_pkg::PHASE_CHARGE);
  assign DISCHARGE_PHASE        = (phase == supply_adc_pkg::PHASE_DISCHARGE);
  assign INPUT_BRIDGE_SEL       = cdr_reg[`CDR_INPUT_SEL_BIT];
  assign GAIN_FOUR              = cdr_reg[`CDR_GAIN_SEL_BIT];
  assign REF_RATIO_HIGH         = cdr_reg[`CDR_REF_RATIO_BIT];
endmodule

// ### supply_adc_monitor.sv
// checker watching the control outputs of the supply and converter block
module supply_adc_monitor (
  input wire logic       MCLK,
  input wire logic       RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       COMPARATOR_IN,
  input wire logic       COMPARATOR_IRQ,
  input wire logic       REGULATOR_ON,
  input wire logic       REFERENCE_ON,
  input wire logic       FILTER_SHORT,
  input wire logic       DOUBLER_ON,
  input wire logic       DOUBLER_BYPASS,
  input wire logic       DOUBLER_CLK,
  input wire logic       REGULATED_OUTPUT_FLOAT,
  input wire logic       CONVERTER_POWER,
  input wire logic       CHOPPER_CLK,
  input wire logic       CHARGE_PHASE,
  input wire logic       DISCHARGE_PHASE,
  input wire logic       INPUT_BRIDGE_SEL,
  input wire logic       GAIN_FOUR,
  input wire logic       REF_RATIO_HIGH
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // register write cycles
  sequence wr_spc; WR && ADDR == 8'h1F; endsequence
  sequence wr_ccr; WR && ADDR == 8'h18; endsequence
  sequence wr_cdr; WR && ADDR == 8'h1A; endsequence
  // output bank relations
  chk_module_off_all: assert property (!REGULATOR_ON |->
    REGULATED_OUTPUT_FLOAT && DOUBLER_BYPASS && !DOUBLER_ON && !CONVERTER_POWER)
    else $error("module off leaves outputs active");
  chk_reference_tracks: assert property (REFERENCE_ON == REGULATOR_ON)
    else $error("reference does not follow regulator");
  chk_bypass_pairs: assert property (DOUBLER_BYPASS != DOUBLER_ON)
    else $error("bypass and doubler disagree");
  chk_enable_write: assert property (wr_spc |-> ##2 REGULATOR_ON == $past(WDATA[0], 2))
    else $error("regulator enable not taken from write");
  chk_fast_start: assert property (wr_spc |-> ##2 FILTER_SHORT == !$past(WDATA[2], 2))
    else $error("filter short not inverse of written bit");
  chk_doubler_write: assert property (wr_spc |-> ##2
    DOUBLER_ON == ($past(WDATA[0], 2) && $past(WDATA[1], 2)))
    else $error("doubler enable not gated by module enable");
  chk_phase_decode: assert property (wr_ccr |=>
    CHARGE_PHASE == ($past(WDATA[2:1]) == 2'b01) && DISCHARGE_PHASE == ($past(WDATA[2:1]) == 2'b10))
    else $error("phase outputs do not decode written code");
  chk_select_bits: assert property (wr_cdr |=>
    {INPUT_BRIDGE_SEL, REF_RATIO_HIGH, GAIN_FOUR} == {$past(WDATA[3]), $past(WDATA[4]), $past(WDATA[7])})
    else $error("select outputs do not follow write");
  chk_chopper_stop: assert property (wr_ccr ##0 !WDATA[6] |-> ##2 !CHOPPER_CLK)
    else $error("chopper clock runs while disabled");
endmodule

// ### tb.sv
// self-checking bench for the supply and converter control block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       MCLK = 1'b0;
  logic       RST_N = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic       WR = 1'b0;
  logic       RD = 1'b0;
  logic       COMPARATOR_IN = 1'b0;
  logic [7:0] RDATA, rd_val, v;
  logic       COMPARATOR_IRQ, REGULATOR_ON, REFERENCE_ON, FILTER_SHORT, DOUBLER_ON, DOUBLER_BYPASS, DOUBLER_CLK;
  logic       REGULATED_OUTPUT_FLOAT, CONVERTER_POWER, CHOPPER_CLK, CHARGE_PHASE, DISCHARGE_PHASE;
  logic       INPUT_BRIDGE_SEL, GAIN_FOUR, REF_RATIO_HIGH;
  int         fail_count = 0;
  int         num_checks = 0;
  logic [7:0] regs [5] = '{8'h1F, 8'h18, 8'h1A, 8'h1B, 8'h10};
  logic [6:0] sup_exp;
  // every turn-on writes fast start low first, raised while on (07) and again while off (04)
  logic [7:0] spc [5] = '{8'h01, 8'h03, 8'h07, 8'h02, 8'h04};
  logic [7:0] cdv [3] = '{8'h08, 8'h80, 8'h10};
  // 5 and 11 are the suggested pump divider loads
  int         nn [4] = '{0, 5, 11, 31};

  `define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

  supply_adc_ctrl supply_adc_ctrl_inst (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .COMPARATOR_IN(COMPARATOR_IN), .COMPARATOR_IRQ(COMPARATOR_IRQ), .REGULATOR_ON(REGULATOR_ON),
    .REFERENCE_ON(REFERENCE_ON), .FILTER_SHORT(FILTER_SHORT), .DOUBLER_ON(DOUBLER_ON), .DOUBLER_BYPASS(DOUBLER_BYPASS),
    .DOUBLER_CLK(DOUBLER_CLK), .REGULATED_OUTPUT_FLOAT(REGULATED_OUTPUT_FLOAT), .CONVERTER_POWER(CONVERTER_POWER),
    .CHOPPER_CLK(CHOPPER_CLK), .CHARGE_PHASE(CHARGE_PHASE), .DISCHARGE_PHASE(DISCHARGE_PHASE),
    .INPUT_BRIDGE_SEL(INPUT_BRIDGE_SEL), .GAIN_FOUR(GAIN_FOUR), .REF_RATIO_HIGH(REF_RATIO_HIGH));

  // 200 MHz system clock
  initial begin
    forever #2.5 MCLK = ~MCLK;
  end

  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask

  // one-cycle read, data taken in the following cycle
  task automatic rd(input logic [7:0] a);
    @(posedge MCLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge MCLK);
    RD <= 1'b0;
    #1;
    rd_val = RDATA;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask

  // supply output bank in one vector
  function automatic logic [6:0] outs_now();
    return {REGULATOR_ON, REFERENCE_ON, DOUBLER_ON, DOUBLER_BYPASS,
            REGULATED_OUTPUT_FLOAT, FILTER_SHORT, CONVERTER_POWER};
  endfunction

  function automatic logic pick(input bit c);
    return c ? CHOPPER_CLK : DOUBLER_CLK;
  endfunction

  // cycles between the second and third rising edge, skipping any old half period
  task automatic measure(input bit c, input int expp);
    int e;
    int n;
    logic last;
    e = 0;
    n = 0;
    last = pick(c);
    for (int t = 0; t < 14000 && e < 3; t++) begin
      @(posedge MCLK);
      #1;
      if (e == 2) n++;
      if (last === 1'b0 && pick(c) === 1'b1) e++;
      last = pick(c);
    end
    `CHK("clock period", expp, n)
  endtask

  task test_done;
    $display("mismatches %0d, checks %0d", fail_count, num_checks);
    if (fail_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // hang guard, well beyond the expected run of about 30k cycles
  initial begin
    repeat (60000) @(posedge MCLK);
    fail_count++;
    test_done;
  end

  // main sequence
  initial begin
    repeat (8) @(posedge MCLK);
    RST_N <= 1'b1;
    settle(0);
    `CHK("reset outputs", 7'b0001110, outs_now())
    foreach (regs[i]) begin
      rd(regs[i]);
      `CHK("reset read", 8'h00, rd_val)
    end
    wr(8'h10, 8'hFF);
    rd(8'h10);
    `CHK("unmapped read", 8'h00, rd_val)
    wr(8'h18, 8'h01);
    foreach (spc[i]) begin
      v = spc[i];
      wr(8'h1F, v); // fast start low at turn-on, hold shortened to fit the run
      settle(1);
      sup_exp = {v[0], v[0], v[0] & v[1], ~(v[0] & v[1]), ~v[0], ~v[2], v[0]};
      `CHK("supply outputs", sup_exp, outs_now())
      rd(8'h1F);
      `CHK("supply readback", v, rd_val)
    end
    for (int p = 0; p < 4; p++) begin
      wr(8'h18, {5'h00, p[1:0], 1'b1});
      settle(0);
      `CHK("phase outputs", {p == 1, p == 2}, {CHARGE_PHASE, DISCHARGE_PHASE})
    end
    wr(8'h18, 8'hFF);
    rd(8'h18);
    `CHK("comparator bit low", 8'h77, rd_val)
    @(posedge MCLK) COMPARATOR_IN <= 1'b1;
    settle(6);
    rd(8'h18);
    `CHK("comparator bit high", 8'h7F, rd_val)
    wr(8'h1A, 8'hFF);
    rd(8'h1A);
    `CHK("divider readback", 8'h9F, rd_val)
    foreach (cdv[i]) begin
      wr(8'h1A, cdv[i]);
      settle(0);
      `CHK("select outputs", {cdv[i][3], cdv[i][7], cdv[i][4]}, {INPUT_BRIDGE_SEL, GAIN_FOUR, REF_RATIO_HIGH})
    end
    foreach (nn[i]) begin
      wr(8'h1F, {nn[i][4:0], 3'b011});
      measure(1'b0, 16 * (nn[i] + 1));
    end
    wr(8'h1F, 8'h01);
    settle(20);
    `CHK("doubler clock stopped", 1'b0, DOUBLER_CLK)
    wr(8'h18, 8'h40);
    for (int n = 0; n < 8; n++) begin
      wr(8'h1A, n[7:0]);
      measure(1'b1, 32 << n);
    end
    wr(8'h18, 8'h00);
    settle(3);
    `CHK("chopper clock stopped", 1'b0, CHOPPER_CLK)
    for (int m = 0; m < 4; m++) begin
      wr(8'h18, {2'b00, m[1:0], 4'h0});
      wr(8'h1B, 8'h01);
      settle(0);
      `CHK("event flag cleared", 1'b0, COMPARATOR_IRQ)
      @(posedge MCLK) COMPARATOR_IN <= 1'b0;
      settle(6);
      `CHK("falling edge event", 1'(m[1]), COMPARATOR_IRQ)
      wr(8'h1B, 8'h01);
      @(posedge MCLK) COMPARATOR_IN <= 1'b1;
      settle(6);
      `CHK("rising edge event", 1'(m[0]), COMPARATOR_IRQ)
    end
    test_done;
  end
endmodule

bind supply_adc_ctrl supply_adc_monitor supply_adc_monitor_inst (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .COMPARATOR_IN(COMPARATOR_IN), .COMPARATOR_IRQ(COMPARATOR_IRQ),
  .REGULATOR_ON(REGULATOR_ON), .REFERENCE_ON(REFERENCE_ON), .FILTER_SHORT(FILTER_SHORT), .DOUBLER_ON(DOUBLER_ON),
  .DOUBLER_BYPASS(DOUBLER_BYPASS), .DOUBLER_CLK(DOUBLER_CLK), .REGULATED_OUTPUT_FLOAT(REGULATED_OUTPUT_FLOAT),
  .CONVERTER_POWER(CONVERTER_POWER), .CHOPPER_CLK(CHOPPER_CLK), .CHARGE_PHASE(CHARGE_PHASE),
  .DISCHARGE_PHASE(DISCHARGE_PHASE), .INPUT_BRIDGE_SEL(INPUT_BRIDGE_SEL), .GAIN_FOUR(GAIN_FOUR),
  .REF_RATIO_HIGH(REF_RATIO_HIGH));
